// file: core/muldiv_pkg.sv
// Shared types and constants of the multiply/divide unit
package muldiv_pkg;

   // Operations issued by the integer pipeline
   typedef enum logic [3:0] {
      OP_NONE                 = 4'h0,
      OP_MULTIPLY_SIGNED      = 4'h1,
      OP_MULTIPLY_UNSIGNED    = 4'h2,
      OP_MULTIPLY_ACCUMULATE  = 4'h3,
      OP_MULTIPLY_ACCUM_U     = 4'h4,
      OP_MULTIPLY_SUBTRACT    = 4'h5,
      OP_MULTIPLY_SUBTRACT_U  = 4'h6,
      OP_MULTIPLY_TO_GPR      = 4'h7,
      OP_DIVIDE_SIGNED        = 4'h8,
      OP_DIVIDE_UNSIGNED      = 4'h9,
      OP_MOVE_FROM_HIGH       = 4'hA,
      OP_MOVE_FROM_LOW        = 4'hB
   } muldiv_op_e;

   // Divider sequencer states
   typedef enum logic [1:0] {
      DV_IDLE = 2'b00,
      DV_RUN  = 2'b01,
      DV_FIX  = 2'b10
   } div_state_e;

   // Request from the execute stage
   typedef struct packed {
      muldiv_op_e  op;
      logic [31:0] first_source_operand;
      logic [31:0] second_source_operand;
   } issue_s;

   // General register write toward writeback
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } wb_s;

   // Skipped iterations per dividend width
   localparam logic [4:0]  DIV_SKIP_W8  = 5'h17;
   localparam logic [4:0]  DIV_SKIP_W16 = 5'h0F;
   localparam logic [4:0]  DIV_SKIP_W24 = 5'h07;
   localparam logic [4:0]  DIV_SKIP_W32 = 5'h00;
   // Divide latency in clocks per dividend width
   localparam logic [5:0]  DIV_LAT_W8   = 6'h0C;
   localparam logic [5:0]  DIV_LAT_W16  = 6'h13;
   localparam logic [5:0]  DIV_LAT_W24  = 6'h1A;
   localparam logic [5:0]  DIV_LAT_W32  = 6'h21;
   // Second array pass weight and reset value
   localparam int          PASS_SHIFT   = 16;
   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

endpackage

// file: core/muldiv_divider.sv
// Early-in iterative divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module muldiv_divider
   import muldiv_pkg::*;
(
   // Clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   // Start request
   input  wire  logic        start,
   input  wire  logic        is_signed,
   input  wire  logic [31:0] dividend,
   input  wire  logic [31:0] divisor,
   // Progress and result
   output logic              stall_more,
   output logic              fin,
   output logic [31:0]       quotient,
   output logic [31:0]       remainder
);

   div_state_e  state_q;
   logic [5:0]  cnt_q;
   logic [5:0]  itr_q;
   logic [31:0] dvd_q;
   logic [31:0] dvs_q;
   logic [31:0] rem_q;
   logic        qneg_q;
   logic        rneg_q;

   // Early-in sign extension check
   wire         w8  = is_signed ? (&dividend[31:7] | ~|dividend[31:7])
                                : ~|dividend[31:8];
   wire         w16 = is_signed ? (&dividend[31:15] | ~|dividend[31:15])
                                : ~|dividend[31:16];
   wire         w24 = is_signed ? (&dividend[31:23] | ~|dividend[31:23])
                                : ~|dividend[31:24];
   wire [4:0]   skip = w8 ? DIV_SKIP_W8 : w16 ? DIV_SKIP_W16 :
                       w24 ? DIV_SKIP_W24 : DIV_SKIP_W32;
   wire [5:0]   lat  = w8 ? DIV_LAT_W8 : w16 ? DIV_LAT_W16 :
                       w24 ? DIV_LAT_W24 : DIV_LAT_W32;
   // Operand magnitudes for signed divide
   wire         neg_a = is_signed & dividend[31];
   wire         neg_b = is_signed & divisor[31];
   wire [31:0]  mag_a = neg_a ? 32'(-dividend) : dividend;
   wire [31:0]  mag_b = neg_b ? 32'(-divisor) : divisor;

   // Restoring subtract step
   wire [33:0]  trial = {1'b0, rem_q, dvd_q[31]} - {2'b00, dvs_q};
   wire         fits  = ~trial[33];
   wire         step  = (state_q == DV_RUN) && (cnt_q <= itr_q);
   wire [31:0]  rem_d = fits ? trial[31:0] : {rem_q[30:0], dvd_q[31]};

   // Sequencer and datapath registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= DV_IDLE;
         cnt_q   <= 6'h00;
         itr_q   <= 6'h00;
         dvd_q   <= RESULT_RESET;
         dvs_q   <= RESULT_RESET;
         rem_q   <= RESULT_RESET;
         qneg_q  <= 1'b0;
         rneg_q  <= 1'b0;
      end else begin
         case (state_q)
            DV_IDLE, DV_FIX: begin
               state_q <= DV_IDLE;
               if (start) begin
                  state_q <= DV_RUN;
                  cnt_q   <= 6'(lat - 6'h01);
                  itr_q   <= 6'(6'h20 - {1'b0, skip});
                  dvd_q   <= mag_a << skip;
                  dvs_q   <= mag_b;
                  rem_q   <= RESULT_RESET;
                  qneg_q  <= neg_a ^ neg_b;
                  rneg_q  <= neg_a;
               end
            end
            DV_RUN: begin
               cnt_q <= 6'(cnt_q - 6'h01);
               if (step) begin
                  rem_q <= rem_d;
                  dvd_q <= {dvd_q[30:0], fits};
               end
               if (cnt_q == 6'h01) begin
                  state_q <= DV_FIX;
               end
            end
            default: state_q <= DV_IDLE;
         endcase
      end
   end

   // Result sign fix and progress flags
   assign quotient   = qneg_q ? 32'(-dvd_q) : dvd_q;
   assign remainder  = rneg_q ? 32'(-rem_q) : rem_q;
   assign fin        = (state_q == DV_FIX);
   assign stall_more = (state_q == DV_RUN) && (cnt_q > 6'h02);

endmodule
`default_nettype wire

// file: core/muldiv_unit.sv
// Multiply/divide unit beside the integer pipeline
// Notes on behaviour
// - Own pipeline keeps advancing during integer stalls.
// - 32x16 array; second operand sets passes.
// - Short operand one pass, full two.
// - Short every clock, full every second.
// - Operand size detected from value and op signedness.
// - Divide resolves one bit per clock.
// - Early-in skips 23, 15, 7 iterations.
// - Issue stalls while a divide runs.
// - Result-pair multiplies latency 1/1, 2/2.
// - Register multiply latency 2/1, 3/2.
// - Divide latency 12,19,26,33 clocks.
// - Results in result pair; moves copy out.
// - Register multiply writes general register.
// - Accumulate adds product to result pair.
// - Subtract removes product from result pair.
// - Operations start in execute stage.
// - Full multiply holds memory stage once.
// - Register result in align, write later.
`timescale 1ns/10ps
`default_nettype none
module muldiv_unit
   import muldiv_pkg::*;
(
   // Clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   // Issue from execute stage
   input  wire  logic        issue_valid,
   input  wire  issue_s      issue,
   input  wire  logic        pipe_hold,
   output logic              issue_stall_q,
   // Results
   output wb_s               wb_q,
   output logic [31:0]       result_high_reg_q,
   output logic [31:0]       result_low_reg_q
);

   logic        m_valid_q;
   muldiv_op_e  m_op_q;
   logic        m_pass2_q;
   logic [63:0] m_acc_q;
   logic [32:0] m_a_q;
   logic [16:0] m_bhi_q;
   logic        al_valid_q;
   logic [31:0] al_data_q;

   // Operation decode
   wire [31:0]  a   = issue.first_source_operand;
   wire [31:0]  b   = issue.second_source_operand;
   muldiv_op_e  op;
   assign op = issue.op;
   wire is_u    = (op == OP_MULTIPLY_UNSIGNED) || (op == OP_MULTIPLY_ACCUM_U) ||
                  (op == OP_MULTIPLY_SUBTRACT_U) || (op == OP_DIVIDE_UNSIGNED);
   wire is_quo  = (op == OP_DIVIDE_SIGNED) || (op == OP_DIVIDE_UNSIGNED);
   wire is_mpy  = (op >= OP_MULTIPLY_SIGNED) && (op <= OP_MULTIPLY_TO_GPR);
   wire is_move = (op == OP_MOVE_FROM_HIGH) || (op == OP_MOVE_FROM_LOW);

   // size comes from the operand value
   wire b_short = is_u ? ~|b[31:16] : (&b[31:15] | ~|b[31:15]);

   // take in execute stage when unstalled
   wire take      = issue_valid & ~pipe_hold & ~issue_stall_q;
   wire take_m    = take & (is_mpy | is_move);
   wire take_quo  = take & is_quo;
   wire take_full = take & is_mpy & ~b_short;

   // shared 32x16 array, second pass on upper half
   wire [32:0]  a_ext  = {~is_u & a[31], a};
   wire [16:0]  b_lo   = {~is_u & b_short & b[15], b[15:0]};
   wire [32:0]  arr_x  = m_pass2_q ? m_a_q : a_ext;
   wire [16:0]  arr_y  = m_pass2_q ? m_bhi_q : b_lo;
   wire signed [49:0] arr_p = $signed(arr_x) * $signed(arr_y);
   wire [63:0]  arr_w  = 64'(arr_p);
   wire [63:0]  pass2  = m_acc_q + (arr_w << PASS_SHIFT);

   // Divider iterates on its own
   logic        div_more;
   logic        div_fin;
   logic [31:0] div_quo;
   logic [31:0] div_rem;

   muldiv_divider u_div (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .start      (take_quo),
      .is_signed  (~is_u),
      .dividend   (a),
      .divisor    (b),
      .stall_more (div_more),
      .fin        (div_fin),
      .quotient   (div_quo),
      .remainder  (div_rem)
   );

   // divide result lands after its latency
   wire [63:0] pair_q    = {result_high_reg_q, result_low_reg_q};
   wire [63:0] pair_base = div_fin ? {div_rem, div_quo} : pair_q;

   // result pair written one stage later
   // commit only once no second pass is pending
   wire m_commit = m_valid_q & ~m_pass2_q;
   wire c_set    = (m_op_q == OP_MULTIPLY_SIGNED) || (m_op_q == OP_MULTIPLY_UNSIGNED);
   wire c_add    = (m_op_q == OP_MULTIPLY_ACCUMULATE) || (m_op_q == OP_MULTIPLY_ACCUM_U);
   wire c_sub    = (m_op_q == OP_MULTIPLY_SUBTRACT) || (m_op_q == OP_MULTIPLY_SUBTRACT_U);
   wire c_gpr    = (m_op_q == OP_MULTIPLY_TO_GPR);

   wire [63:0] pair_d = (m_commit & c_set) ? m_acc_q :
                        (m_commit & c_add) ? pair_base + m_acc_q :
                        (m_commit & c_sub) ? pair_base - m_acc_q : pair_base;
   // moves copy a half of the pair
   wire [31:0] move_val = (m_op_q == OP_MOVE_FROM_HIGH) ? pair_base[63:32] : pair_base[31:0];
   wire        al_d     = m_commit & (c_gpr | (m_op_q >= OP_MOVE_FROM_HIGH));
   // full multiply and running divide stall issue
   wire        stall_d  = take_full | take_quo | div_more;

   // memory stage advances regardless of pipe_hold
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         m_valid_q <= 1'b0;
         m_op_q    <= OP_NONE;
         m_pass2_q <= 1'b0;
         m_acc_q   <= 64'h0;
         m_a_q     <= 33'h0;
         m_bhi_q   <= 17'h0;
      end else if (take_m) begin
         m_valid_q <= 1'b1;
         m_op_q    <= op;
         m_pass2_q <= take_full;
         m_acc_q   <= arr_w;
         m_a_q     <= a_ext;
         m_bhi_q   <= {~is_u & b[31], b[31:16]};
      end else if (m_pass2_q) begin
         m_pass2_q <= 1'b0;
         m_acc_q   <= pass2;
      end else begin
         m_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         issue_stall_q     <= 1'b0;
         result_high_reg_q <= RESULT_RESET;
         result_low_reg_q  <= RESULT_RESET;
      end else begin
         issue_stall_q     <= stall_d;
         result_high_reg_q <= pair_d[63:32];
         result_low_reg_q  <= pair_d[31:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         al_valid_q <= 1'b0;
         al_data_q  <= RESULT_RESET;
         wb_q       <= '0;
      end else begin
         al_valid_q <= al_d;
         al_data_q  <= c_gpr ? m_acc_q[31:0] : move_val;
         wb_q       <= '{valid: al_valid_q, data: al_data_q};
      end
   end

   // Reference products for checking
   logic signed [63:0] exp_s;
   logic [63:0]        exp_u;
   assign exp_s = $signed(a) * $signed(b);
   assign exp_u = {32'h0, a} * {32'h0, b};
   wire t_short_s = take & (op == OP_MULTIPLY_SIGNED) & b_short;
   wire t_full_u  = take & (op == OP_MULTIPLY_UNSIGNED) & ~b_short;
   wire t_gpr     = take & (op == OP_MULTIPLY_TO_GPR);
   wire t_mac     = take & (op == OP_MULTIPLY_ACCUMULATE) & b_short;
   wire t_quo8    = take_quo & is_u & ~|a[31:8];
   wire t_quo32   = take_quo & is_u & a[31];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   full_stall_a: assert property (take_full |=> issue_stall_q ##1 !issue_stall_q)
      else $error("full multiply repeat rate wrong");
   short_free_a: assert property (take & is_mpy & b_short |=> !issue_stall_q)
      else $error("short multiply stalled issue");
   short_lat_a: assert property (t_short_s |=> ##1 pair_q == $past(exp_s, 2))
      else $error("short multiply result late or wrong");
   full_lat_a: assert property (t_full_u |=> ##2 pair_q == $past(exp_u, 3))
      else $error("full multiply result late or wrong");
   gpr_short_a: assert property (t_gpr & b_short |-> ##3 wb_q.valid && wb_q.data == $past(exp_s[31:0], 3))
      else $error("register multiply short latency");
   gpr_full_a: assert property (t_gpr & ~b_short |-> ##3 !wb_q.valid ##1 wb_q.valid)
      else $error("register multiply full latency");
   mac_sum_a: assert property (t_mac ##1 !div_fin |=> pair_q == $past(pair_q) + $past(exp_s, 2))
      else $error("accumulate sum wrong");
   div_stall_a: assert property (take_quo |=> issue_stall_q [*8])
      else $error("issue not stalled during divide");
   div8_lat_a: assert property (t_quo8 |-> ##12 div_fin && div_quo == $past(a, 12) / $past(b, 12))
      else $error("short divide latency or quotient");
   div32_lat_a: assert property (t_quo32 |-> ##32 !issue_stall_q ##1 div_fin)
      else $error("full divide latency");

   mac_burst_c: cover property (t_mac ##1 t_mac ##1 t_mac);
   full_pair_c: cover property (take_full ##2 take_full);
   div_done_c:  cover property (take_quo ##[11:33] div_fin);
   hold_run_c:  cover property (m_pass2_q && pipe_hold);

endmodule
`default_nettype wire

// file: tb/int_pipe_model.sv
// Integer pipeline model issuing operations to the unit
`timescale 1ns/10ps
`default_nettype none
module int_pipe_model
   import muldiv_pkg::*;
(
   // Clock and unit answer
   input  wire logic   ref_clk,
   input  wire logic   issue_stall_q,
   // Issue toward the unit
   output var  logic   issue_valid,
   output var  issue_s issue,
   output var  logic   pipe_hold
);
   logic hold_rnd;
   int   cyc = 0;
   int   tk;

   // Idle request at time zero
   initial begin
      issue_valid = 1'b0;
      issue = '0;
      hold_rnd = 1'b0;
   end

   // Edge count for take times
   always @(posedge ref_clk) cyc <= cyc + 1;

   // Random integer stalls when enabled
   always @(negedge ref_clk) pipe_hold <= hold_rnd & ($urandom_range(3) == 0);

   // Present one op in execute, hold it until taken
   task automatic send(input muldiv_op_e op, input logic [31:0] a, input logic [31:0] b);
      issue_valid = 1'b1;
      issue = {op, a, b};
      #1;
      while (issue_stall_q || pipe_hold) begin
         @(negedge ref_clk);
         #1;
      end
      @(posedge ref_clk);
      @(negedge ref_clk);
      tk = cyc;
   endtask

   // Release request, scramble stale fields
   task automatic idle();
      issue_valid = 1'b0;
      issue = ~issue;
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the multiply/divide unit
`timescale 1ns/10ps
`default_nettype none
module testbench
   import muldiv_pkg::*;
;
   logic        ref_clk;
   logic        rst;
   logic        issue_valid;
   issue_s      issue;
   logic        pipe_hold;
   logic        issue_stall_q;
   wb_s         wb_q;
   logic [31:0] res_high;
   logic [31:0] res_low;
   int          error_cnt;
   int          compares;
   muldiv_op_e  ops [11] = '{OP_MULTIPLY_SIGNED, OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_ACCUMULATE,
      OP_MULTIPLY_ACCUM_U, OP_MULTIPLY_SUBTRACT, OP_MULTIPLY_SUBTRACT_U, OP_MULTIPLY_TO_GPR,
      OP_DIVIDE_SIGNED, OP_DIVIDE_UNSIGNED, OP_MOVE_FROM_HIGH, OP_MOVE_FROM_LOW};

   muldiv_unit u_dut (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .issue(issue),
      .pipe_hold(pipe_hold), .issue_stall_q(issue_stall_q), .wb_q(wb_q),
      .result_high_reg_q(res_high), .result_low_reg_q(res_low));
   int_pipe_model u_pipe (.ref_clk(ref_clk), .issue_stall_q(issue_stall_q),
      .issue_valid(issue_valid), .issue(issue), .pipe_hold(pipe_hold));

   // Core clock
   always #50 ref_clk = ~ref_clk;

   // Expected values
   function automatic logic is_sgn(input muldiv_op_e op);
      return op inside {OP_MULTIPLY_SIGNED, OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT,
         OP_MULTIPLY_TO_GPR, OP_DIVIDE_SIGNED};
   endfunction
   function automatic logic [63:0] prod(input logic s, input logic [31:0] a, input logic [31:0] b);
      logic signed [63:0] x;
      logic signed [63:0] y;
      x = s ? $signed(a) : $signed({1'b0, a});
      y = s ? $signed(b) : $signed({1'b0, b});
      return x * y;
   endfunction
   function automatic logic [63:0] nxt(input muldiv_op_e op, input logic [31:0] a,
      input logic [31:0] b, input logic [63:0] p);
      logic [63:0] m;
      m = prod(is_sgn(op), a, b);
      case (op)
         OP_MULTIPLY_SIGNED, OP_MULTIPLY_UNSIGNED: return m;
         OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_ACCUM_U: return p + m;
         OP_MULTIPLY_SUBTRACT, OP_MULTIPLY_SUBTRACT_U: return p - m;
         OP_DIVIDE_SIGNED: return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
         OP_DIVIDE_UNSIGNED: return {a % b, a / b};
         default: return p;
      endcase
   endfunction
   function automatic int lat(input muldiv_op_e op, input logic [31:0] a, input logic [31:0] b);
      logic s;
      logic sh;
      s = is_sgn(op);
      sh = s ? (b[31:15] == {17{b[15]}}) : (b[31:16] == 16'h0000);
      if (op == OP_MULTIPLY_TO_GPR) return sh ? 2 : 3;
      if (op == OP_MOVE_FROM_HIGH || op == OP_MOVE_FROM_LOW) return 2;
      if (op == OP_DIVIDE_SIGNED || op == OP_DIVIDE_UNSIGNED) begin
         for (int w = 8; w < 32; w += 8)
            if (s ? ((a ^ {32{a[w-1]}}) >> (w - 1)) == 0 : (a >> w) == 0) return 5 + 7 * w / 8;
         return 33;
      end
      return sh ? 1 : 2;
   endfunction
   function automatic logic [31:0] mk_a(input logic s, input int w);
      logic [31:0] v;
      v = $urandom;
      return s ? 32'($signed(v << (32 - w)) >>> (32 - w)) : v >> (32 - w);
   endfunction
   function automatic logic [31:0] mk_b(input logic s, input logic full);
      logic [31:0] r;
      r = $urandom;
      if (full) return {2'b01, r[29:0]};
      if (r[15:0] == 16'h0000) r[0] = 1'b1;
      return s ? {{16{r[15]}}, r[15:0]} : {16'h0000, r[15:0]};
   endfunction

   // Compare tasks
   task automatic cmp_pair(input logic [63:0] e);
      compares++;
      if ({res_high, res_low} !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {res_high, res_low}, e);
      end
   endtask
   task automatic cmp_wb(input logic v, input logic [31:0] d);
      compares++;
      if (wb_q.valid !== v || (v && wb_q.data !== d)) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wb_q, {v, d});
      end
   endtask
   task automatic cmp_gap(input int got, input int e);
      compares++;
      if (got != e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask

   // One op alone: result exactly at its latency
   task automatic run(input muldiv_op_e op, input logic [31:0] a, input logic [31:0] b);
      int          l;
      logic [63:0] p;
      logic [63:0] e;
      logic [63:0] m;
      logic        wbk;
      l = lat(op, a, b);
      p = {res_high, res_low};
      e = nxt(op, a, b, p);
      m = prod(1'b1, a, b);
      wbk = op inside {OP_MULTIPLY_TO_GPR, OP_MOVE_FROM_HIGH, OP_MOVE_FROM_LOW};
      if (op == OP_MOVE_FROM_HIGH) m[31:0] = p[63:32];
      if (op == OP_MOVE_FROM_LOW) m[31:0] = p[31:0];
      u_pipe.send(op, a, b);
      u_pipe.idle();
      repeat (l - 1) @(negedge ref_clk);
      cmp_pair(p);
      cmp_wb(1'b0, 32'h0000_0000);
      @(negedge ref_clk);
      cmp_pair(e);
      cmp_wb(wbk, m[31:0]);
      @(negedge ref_clk);
      cmp_wb(1'b0, 32'h0000_0000);
   endtask

   task automatic final_report();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial begin
      #3_000_000;
      error_cnt++;
      final_report();
   end

   // Main sequence
   initial begin
      logic [31:0] a;
      logic [31:0] b;
      logic [63:0] p;
      muldiv_op_e  op;
      int          t0;
      int          l;
      ref_clk = 1'b0;
      rst = 1'b1;
      error_cnt = 0;
      compares = 0;
      void'($urandom(3130));
      repeat (12) @(negedge ref_clk);
      cmp_pair(64'h0);
      rst = 1'b0;
      @(negedge ref_clk);
      // Every op with short and full second operand
      foreach (ops[i])
         for (int f = 0; f < 2; f++)
            run(ops[i], mk_a(is_sgn(ops[i]), 32), mk_b(is_sgn(ops[i]), f[0]));
      // Back-to-back accumulates and subtracts, short then full
      for (int f = 0; f < 2; f++) begin
         p = {res_high, res_low};
         for (int i = 0; i < 4; i++) begin
            op = i[0] ? OP_MULTIPLY_SUBTRACT : OP_MULTIPLY_ACCUMULATE;
            a = mk_a(1'b1, 32);
            b = mk_b(1'b1, f[0]);
            u_pipe.send(op, a, b);
            if (i > 0) cmp_gap(u_pipe.tk - t0, 1 + f);
            cmp_pair(p);
            t0 = u_pipe.tk;
            p = nxt(op, a, b, p);
         end
         u_pipe.idle();
         repeat (1 + f) @(negedge ref_clk);
         cmp_pair(p);
      end
      // Divides of every width, next op held off until one clock before the result lands
      for (int w = 8; w <= 32; w += 8)
         for (int s = 0; s < 2; s++) begin
            op = s[0] ? OP_DIVIDE_SIGNED : OP_DIVIDE_UNSIGNED;
            a = mk_a(s[0], w);
            b = mk_b(s[0], 1'b1);
            l = lat(op, a, b);
            p = {res_high, res_low};
            u_pipe.send(op, a, b);
            t0 = u_pipe.tk;
            u_pipe.send(OP_NONE, mk_a(1'b0, 32), mk_a(1'b0, 32));
            u_pipe.idle();
            cmp_gap(u_pipe.tk - t0, l - 1);
            cmp_pair(p);
            @(negedge ref_clk);
            cmp_pair(nxt(op, a, b, p));
         end
      // Random ops while the integer pipeline stalls at random
      u_pipe.hold_rnd = 1'b1;
      for (int i = 0; i < 40; i++) begin
         op = ops[$urandom_range(10)];
         a = mk_a(is_sgn(op), 8 * $urandom_range(4, 1));
         b = mk_b(is_sgn(op), 1'($urandom));
         if (b == 32'h0000_0000) b = 32'h0000_0001;
         run(op, a, b);
      end
      u_pipe.hold_rnd = 1'b0;
      final_report();
   end
endmodule
`default_nettype wire
